// File: dv/ssr_contacts.sv
// contact and plc output model facing the terminal inputs
`timescale 1ns/1ps
module ssr_contacts (
  input wire logic mclk_i,
  output logic fwd_o,
  output logic rs_o,
  output logic [5:0] mf_o
);
  // contacts open at power up
  initial begin
    fwd_o = 1'b0;
    rs_o = 1'b0;
    mf_o = 6'h00;
  end
  // set all contact levels just after an edge
  task automatic set(input logic f, input logic r, input logic [5:0] m);
    @(posedge mclk_i);
    fwd_o <= f;
    rs_o <= r;
    mf_o <= m;
  endtask
  // run contact hold
  // close the run contact for n cycles, then open it
  task automatic pulse_run(input int n);
    @(posedge mclk_i);
    fwd_o <= 1'b1;
    repeat (n) @(posedge mclk_i);
    fwd_o <= 1'b0;
  endtask
endmodule

// File: dv/ssr_top_tb.sv
// self-checking bench of the speed step and run select block
`timescale 1ns/1ps
module ssr_top_tb;
  import ssr_pkg::*;
  localparam int HOLD = 8;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] keys = 4'h0; // run, stop, jog, dir
  logic [15:0] an1 = 16'h1111;
  logic [15:0] an2 = 16'h2222;
  logic [15:0] an3 = 16'h3333;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic fwd, rs;
  logic [5:0] mf;
  ssr_cmd_t cmd_o;
  logic [15:0] freq_ref_o;
  int errors = 0;
  int comparisons = 0;
  // ******************************************************
  // clock, design and contacts
  // ******************************************************
  always #20 mclk_i = ~mclk_i;
  ssr_top #(.RUN_HOLD(HOLD)) dut_u (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .forward_run_terminal_i(fwd),
    .reverse_or_stop_terminal_i(rs), .mf_contact_i(mf), .key_run_i(keys[0]),
    .key_stop_i(keys[1]), .key_jog_i(keys[2]), .key_dir_i(keys[3]),
    .primary_analog_input_i(an1), .second_analog_input_i(an2),
    .third_analog_input_i(an3), .cmd_o(cmd_o), .freq_ref_o(freq_ref_o));
  ssr_contacts contacts_u (.mclk_i(mclk_i), .fwd_o(fwd), .rs_o(rs), .mf_o(mf));
  // ******************************************************
  // shared tasks
  // ******************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // one apb transfer, waits for pready
  task automatic apb(input logic w, input logic [9:0] ix, input logic [15:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge mclk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge mclk_i);
    penable <= 1'b1;
    do begin
      @(posedge mclk_i);
    end while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] ix, input logic [15:0] d, input logic x);
    logic [31:0] r;
    logic e;
    apb(1'b1, ix, d, r, e);
    check({31'h0, e}, {31'h0, x});
  endtask
  task automatic rd(input logic [9:0] ix, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, ix, 16'h0000, r, e);
    check(r, x);
    check({31'h0, e}, {31'h0, xe});
  endtask
  task automatic settle;
    repeat (3) @(posedge mclk_i);
    #1;
  endtask
  task automatic key(input int b);
    @(posedge mclk_i);
    keys[b] <= 1'b1;
    @(posedge mclk_i);
    keys[b] <= 1'b0;
    settle();
  endtask
  task automatic cmd_is(input logic [2:0] x);
    check({29'h0, cmd_o}, {29'h0, x});
  endtask
  // ******************************************************
  // scenarios
  // ******************************************************
  task automatic t_regs;
    rd(IX_RUN_SRC, 32'h1, 1'b0);
    rd(10'h3FF, 32'h0, 1'b1);
    for (int v = 0; v < 5; v++) wr(IX_RUN_SRC, 16'(v), v > 3);
    rd(IX_RUN_SRC, 32'h3, 1'b0);
    wr(IX_RUN_SRC, RS_TERM, 1'b0);
  endtask
  task automatic t_steps;
    wr(IX_FREQ_SRC, 16'h0000, 1'b0);
    for (int i = 0; i < 9; i++) wr(10'(IX_PRESET0 + i), 16'(16'hA000 + i), 1'b0);
    for (int k = 0; k < 8; k++) begin
      contacts_u.set(1'b0, 1'b0, {1'b0, 3'(k), 2'b00});
      settle();
      check({16'h0, freq_ref_o}, 32'(32'hA000 + k));
    end
    contacts_u.set(1'b0, 1'b0, 6'b111100);
    settle();
    check({16'h0, freq_ref_o}, 32'hA008);
  endtask
  task automatic t_analog;
    wr(IX_FREQ_SRC, FS_ANALOG, 1'b0);
    contacts_u.set(1'b0, 1'b0, 6'b000000);
    settle();
    check({16'h0, freq_ref_o}, {16'h0, an1});
    wr(IX_AN2_FUNC, AF_AUX1, 1'b0);
    wr(IX_AN3_FUNC, AF_AUX1, 1'b1);
    wr(IX_AN3_FUNC, AF_AUX2, 1'b0);
    contacts_u.set(1'b0, 1'b0, 6'b000100);
    settle();
    check({16'h0, freq_ref_o}, {16'h0, an2});
    contacts_u.set(1'b0, 1'b0, 6'b001000);
    settle();
    check({16'h0, freq_ref_o}, {16'h0, an3});
  endtask
  task automatic t_two_wire;
    contacts_u.set(1'b1, 1'b0, 6'b000000);
    settle();
    cmd_is(3'b100);
    wr(IX_RUN_SRC, RS_KEYPAD, 1'b1);
    contacts_u.set(1'b0, 1'b1, 6'b000000);
    settle();
    cmd_is(3'b110);
    contacts_u.set(1'b0, 1'b0, 6'b000000);
    settle();
    cmd_is(3'b000);
  endtask
  task automatic t_keypad;
    wr(IX_RUN_SRC, RS_KEYPAD, 1'b0);
    key(3);
    key(0);
    cmd_is(3'b110);
    key(1);
    cmd_is(3'b010);
    @(posedge mclk_i);
    keys[2] <= 1'b1;
    settle();
    check({30'h0, cmd_o.run, cmd_o.jog}, 32'h3);
    check({16'h0, freq_ref_o}, 32'hA008);
    @(posedge mclk_i);
    keys[2] <= 1'b0;
    settle();
    cmd_is(3'b010);
    wr(IX_RUN_SRC, RS_TERM, 1'b0);
  endtask
  task automatic t_three_wire;
    wr(IX_INIT, INIT_3WIRE, 1'b0);
    rd(10'(IX_CFUNC0 + 2), {16'h0, FN_DIR}, 1'b0);
    contacts_u.set(1'b0, 1'b1, 6'b000000);
    contacts_u.pulse_run(4);
    settle();
    cmd_is(3'b000);
    contacts_u.pulse_run(HOLD + 2);
    settle();
    cmd_is(3'b100);
    contacts_u.set(1'b0, 1'b1, 6'b000100);
    settle();
    cmd_is(3'b110);
    rd(IX_STATUS, 32'hB, 1'b0);
    contacts_u.set(1'b0, 1'b0, 6'b000100);
    settle();
    cmd_is(3'b010);
  endtask
  // ******************************************************
  // main sequence and watchdog
  // ******************************************************
  initial begin
    repeat (16) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_regs();
    t_steps();
    t_analog();
    t_two_wire();
    t_keypad();
    t_three_wire();
    complete_run();
  end
  // cut a hang short well past the expected run length
  initial begin
    #(40 * 30000);
    errors++;
    complete_run();
  end
endmodule

// File: hw/ssr_pkg.sv
// package: register map, codes and timing of the speed step and run select block
package ssr_pkg;
  // ******************************************************
  // register indexes, byte address is four times the index
  // ******************************************************
  localparam logic [9:0] IX_FREQ_SRC = 10'h180;
  localparam logic [9:0] IX_RUN_SRC = 10'h181;
  localparam logic [9:0] IX_AN3_FUNC = 10'h190;
  localparam logic [9:0] IX_AN2_FUNC = 10'h191;
  localparam logic [9:0] IX_CFUNC0 = 10'h1A0; // six contact functions
  localparam logic [9:0] IX_PRESET0 = 10'h1B0; // eight presets, jog at +8
  localparam logic [9:0] IX_INIT = 10'h1C0;
  localparam logic [9:0] IX_STATUS = 10'h1D0;
  localparam logic [9:0] IX_FREF = 10'h1D1;
  localparam logic [3:0] N_CFUNC = 4'h6;
  localparam logic [3:0] N_PRESET = 4'h9;
  localparam logic [3:0] JOG_SLOT = 4'h8;
  // ******************************************************
  // reset values and codes
  // ******************************************************
  localparam logic [15:0] RST_FREQ_SRC = 16'h0001;
  localparam logic [15:0] RST_RUN_SRC = 16'h0001;
  localparam logic [15:0] RST_AN3_FUNC = 16'h001F;
  localparam logic [15:0] RST_AN2_FUNC = 16'h0000;
  localparam logic [15:0] RST_PRESET = 16'h0000;
  localparam logic [15:0] FN_DIR = 16'h0000;
  localparam logic [15:0] FN_STEP0 = 16'h0003;
  localparam logic [15:0] FN_STEP1 = 16'h0004;
  localparam logic [15:0] FN_STEP2 = 16'h0005;
  localparam logic [15:0] FN_JOG = 16'h0006;
  localparam logic [15:0] FN_NONE = 16'h000F;
  localparam logic [15:0] AF_AUX1 = 16'h0002;
  localparam logic [15:0] AF_AUX2 = 16'h0003;
  localparam logic [15:0] FS_ANALOG = 16'h0001;
  localparam logic [15:0] RS_KEYPAD = 16'h0000;
  localparam logic [15:0] RS_TERM = 16'h0001;
  localparam logic [15:0] RS_MAX = 16'h0003;
  localparam logic [15:0] INIT_3WIRE = 16'h0001;
  // ******************************************************
  // timing
  // ******************************************************
  localparam int CLK_HZ = 25000000;
  localparam int T_RUN_HOLD_MS = 50;
  localparam int RUN_HOLD_CYC = T_RUN_HOLD_MS * (CLK_HZ / 1000);
  // run command to the drive
  typedef struct packed {
    logic run;
    logic rev;
    logic jog;
  } ssr_cmd_t;
  typedef enum logic [1:0] {
    TW_IDLE = 2'b00,
    TW_HOLD = 2'b01,
    TW_RUN = 2'b10
  } ssr_tw_state_t;
endpackage

// File: hw/ssr_top.sv
// speed step and run command select with apb register access
// Operation
// - without jog, three step contacts pick preset 1..8, first is lsb
// - jog contact on selects the jog speed over the step contacts
// - step 1 uses primary analog when frequency source is 1, else preset
// - step 2 uses analog input whose function is 2, else preset 2
// - step 3 uses analog input whose function is 3, else preset 3
// - both analog function settings never hold the same value
// - run source 0..3, reset 1, unchangeable while running
// - run source 0 takes run, stop, jog, direction from keypad keys
// - run source 1 takes run commands from control terminals
// - two-wire: forward or reverse terminal alone runs, both closed or release stops
// - any contact function 0 gives three-wire, that contact sets direction
// - three-wire initialise puts direction function on input 3
// - three-wire run held 50 ms latches run internally
// - contact functions 3, 4, 5, 6 give step bits 0..2 and jog
`timescale 1ns/1ps
module ssr_top
  import ssr_pkg::*;
#(
  parameter int RUN_HOLD = RUN_HOLD_CYC
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic forward_run_terminal_i,
  input wire logic reverse_or_stop_terminal_i,
  input wire logic [5:0] mf_contact_i,
  input wire logic key_run_i,
  input wire logic key_stop_i,
  input wire logic key_jog_i,
  input wire logic key_dir_i,
  input wire logic [15:0] primary_analog_input_i,
  input wire logic [15:0] second_analog_input_i,
  input wire logic [15:0] third_analog_input_i,
  output ssr_cmd_t cmd_o,
  output logic [15:0] freq_ref_o
);
  localparam int CW = $clog2(RUN_HOLD + 1);

  if (RUN_HOLD < 2) begin : g_chk
    $error("RUN_HOLD must be at least 2");
  end

  // ******************************************************
  // state
  // ******************************************************
  logic [15:0] freq_src_reg;
  logic [15:0] run_src_reg;
  logic [15:0] an3_func_reg;
  logic [15:0] an2_func_reg;
  logic [15:0] cfunc_reg [0:5];
  logic [15:0] preset_mem [0:8];
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic kp_run_reg;
  logic kp_rev_reg;
  logic kp_run_next;
  logic kp_rev_next;
  ssr_tw_state_t tw_reg;
  ssr_tw_state_t tw_next;
  logic [CW-1:0] hold_reg;
  ssr_cmd_t cmd_reg;
  ssr_cmd_t cmd_next;
  logic [15:0] fref_reg;
  logic [15:0] fref_next;
  logic [9:0] idx;
  logic setup;
  logic done;
  logic wr_en;
  logic bad;
  logic [15:0] rd_val;
  logic [2:0] step;
  logic jog_sel;
  logic jog_ref;
  logic three_wire;
  logic dir_in;
  logic tw_act;
  logic stop_term;
  logic [15:0] status;

  assign idx = paddr_i[11:2];
  assign setup = psel_i & ~penable_i;
  assign done = psel_i & penable_i & pready_reg;
  assign wr_en = done & pwrite_i & ~pslverr_reg;
  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign cmd_o = cmd_reg;
  assign freq_ref_o = fref_reg;
  assign stop_term = reverse_or_stop_terminal_i;
  assign status = {9'h000, step, three_wire, cmd_reg.jog, cmd_reg.rev, cmd_reg.run};

  // ******************************************************
  // apb decode
  // ******************************************************
  // read value and refusal of the addressed word
  always_comb begin
    rd_val = 16'h0000;
    bad = 1'b0;
    if (idx == IX_FREQ_SRC) begin
      rd_val = freq_src_reg;
    end else if (idx == IX_RUN_SRC) begin
      rd_val = run_src_reg;
      bad = pwrite_i & ((pwdata_i[15:0] > RS_MAX) | cmd_reg.run);
    end else if (idx == IX_AN3_FUNC) begin
      rd_val = an3_func_reg;
      bad = pwrite_i & (pwdata_i[15:0] == an2_func_reg);
    end else if (idx == IX_AN2_FUNC) begin
      rd_val = an2_func_reg;
      bad = pwrite_i & (pwdata_i[15:0] == an3_func_reg);
    end else if (idx[9:4] == IX_CFUNC0[9:4] && idx[3:0] < N_CFUNC) begin
      rd_val = cfunc_reg[idx[2:0]];
    end else if (idx[9:4] == IX_PRESET0[9:4] && idx[3:0] < N_PRESET) begin
      rd_val = preset_mem[idx[3:0]];
    end else if (idx == IX_INIT) begin
      rd_val = 16'h0000;
    end else if (idx == IX_STATUS || idx == IX_FREF) begin
      rd_val = (idx == IX_STATUS) ? status : fref_reg;
      bad = pwrite_i;
    end else begin
      bad = 1'b1;
    end
  end

  // answer one cycle after setup, held through the access phase
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else if (setup) begin
      pready_reg <= 1'b1;
      pslverr_reg <= bad;
      prdata_reg <= {16'h0000, bad ? 16'h0000 : rd_val};
    end else if (done) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  // ******************************************************
  // configuration registers
  // ******************************************************
  // selection settings and contact functions
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      freq_src_reg <= RST_FREQ_SRC;
      run_src_reg <= RST_RUN_SRC;
      an3_func_reg <= RST_AN3_FUNC;
      an2_func_reg <= RST_AN2_FUNC;
      cfunc_reg[0] <= FN_NONE;
      cfunc_reg[1] <= FN_NONE;
      cfunc_reg[2] <= FN_STEP0;
      cfunc_reg[3] <= FN_STEP1;
      cfunc_reg[4] <= FN_STEP2;
      cfunc_reg[5] <= FN_JOG;
    end else if (wr_en) begin
      if (idx == IX_FREQ_SRC) begin
        freq_src_reg <= pwdata_i[15:0];
      end
      // late start also blocks the change
      if (idx == IX_RUN_SRC && !cmd_reg.run) begin
        run_src_reg <= pwdata_i[15:0];
      end
      if (idx == IX_AN3_FUNC) begin
        an3_func_reg <= pwdata_i[15:0];
      end
      if (idx == IX_AN2_FUNC) begin
        an2_func_reg <= pwdata_i[15:0];
      end
      if (idx[9:4] == IX_CFUNC0[9:4] && idx[3:0] < N_CFUNC) begin
        cfunc_reg[idx[2:0]] <= pwdata_i[15:0];
      end
      // initialise moves direction to input 3
      if (idx == IX_INIT) begin
        cfunc_reg[2] <= (pwdata_i[15:0] == INIT_3WIRE) ? FN_DIR : FN_STEP0;
      end
    end
  end

  // preset and jog speed words
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < 9; i++) begin
        preset_mem[i] <= RST_PRESET;
      end
    end else if (wr_en && idx[9:4] == IX_PRESET0[9:4] && idx[3:0] < N_PRESET) begin
      preset_mem[idx[3:0]] <= pwdata_i[15:0];
    end
  end

  // ******************************************************
  // contact function decode
  // ******************************************************
  // map contacts onto step bits, jog and direction
  always_comb begin
    step = 3'h0;
    jog_sel = 1'b0;
    three_wire = 1'b0;
    dir_in = 1'b0;
    for (int i = 0; i < 6; i++) begin
      step[0] = step[0] | (mf_contact_i[i] & (cfunc_reg[i] == FN_STEP0));
      step[1] = step[1] | (mf_contact_i[i] & (cfunc_reg[i] == FN_STEP1));
      step[2] = step[2] | (mf_contact_i[i] & (cfunc_reg[i] == FN_STEP2));
      jog_sel = jog_sel | (mf_contact_i[i] & (cfunc_reg[i] == FN_JOG));
      three_wire = three_wire | (cfunc_reg[i] == FN_DIR);
      dir_in = dir_in | (mf_contact_i[i] & (cfunc_reg[i] == FN_DIR));
    end
  end

  assign jog_ref = jog_sel | ((run_src_reg == RS_KEYPAD) & key_jog_i);

  // ******************************************************
  // frequency reference select
  // ******************************************************
  always_comb begin
    fref_next = preset_mem[{1'b0, step}];
    if (jog_ref) begin
      fref_next = preset_mem[JOG_SLOT];
    end else if (step == 3'h0) begin
      fref_next = (freq_src_reg == FS_ANALOG) ? primary_analog_input_i : preset_mem[0];
    end else if (step == 3'h1) begin
      if (an2_func_reg == AF_AUX1) begin
        fref_next = second_analog_input_i;
      end else if (an3_func_reg == AF_AUX1) begin
        fref_next = third_analog_input_i;
      end
    end else if (step == 3'h2) begin
      if (an3_func_reg == AF_AUX2) begin
        fref_next = third_analog_input_i;
      end else if (an2_func_reg == AF_AUX2) begin
        fref_next = second_analog_input_i;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fref_reg <= 16'h0000;
    end else begin
      fref_reg <= fref_next;
    end
  end

  // ******************************************************
  // keypad run latch
  // ******************************************************
  // stop wins over run, direction key toggles
  always_comb begin
    kp_run_next = key_stop_i ? 1'b0 : (key_run_i | kp_run_reg);
    kp_rev_next = kp_rev_reg ^ key_dir_i;
    if (run_src_reg != RS_KEYPAD) begin
      kp_run_next = 1'b0;
      kp_rev_next = kp_rev_reg;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      kp_run_reg <= 1'b0;
      kp_rev_reg <= 1'b0;
    end else begin
      kp_run_reg <= kp_run_next;
      kp_rev_reg <= kp_rev_next;
    end
  end

  // ******************************************************
  // three-wire sequence
  // ******************************************************
  assign tw_act = (run_src_reg == RS_TERM) & three_wire;

  always_comb begin
    tw_next = tw_reg;
    unique case (tw_reg)
      TW_IDLE: begin
        if (forward_run_terminal_i && stop_term) begin
          tw_next = TW_HOLD;
        end
      end
      TW_HOLD: begin
        if (!(forward_run_terminal_i && stop_term)) begin
          tw_next = TW_IDLE;
        end else if (hold_reg == CW'(RUN_HOLD - 1)) begin
          tw_next = TW_RUN;
        end
      end
      TW_RUN: begin
        if (!stop_term) begin
          tw_next = TW_IDLE;
        end
      end
      default: tw_next = TW_IDLE;
    endcase
    if (!tw_act) begin
      tw_next = TW_IDLE;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tw_reg <= TW_IDLE;
      hold_reg <= '0;
    end else begin
      tw_reg <= tw_next;
      hold_reg <= (tw_next == TW_HOLD && tw_reg == TW_HOLD) ? hold_reg + 1'b1 : '0;
    end
  end

  // ******************************************************
  // run command output
  // ******************************************************
  always_comb begin
    cmd_next = '0;
    if (run_src_reg == RS_KEYPAD) begin
      cmd_next.run = kp_run_next | key_jog_i;
      cmd_next.rev = kp_rev_next;
    end else if (run_src_reg == RS_TERM) begin
      if (three_wire) begin
        cmd_next.run = (tw_reg == TW_RUN) & stop_term;
        cmd_next.rev = dir_in;
      end else begin
        cmd_next.run = forward_run_terminal_i ^ stop_term;
        cmd_next.rev = stop_term & ~forward_run_terminal_i;
      end
    end
    cmd_next.jog = jog_ref & cmd_next.run;
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmd_reg <= '0;
    end else begin
      cmd_reg <= cmd_next;
    end
  end

  // ******************************************************
  // checks
  // ******************************************************
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);

  a_step_six: assert property (
    !jog_ref && step == 3'h5 |=> freq_ref_o == $past(preset_mem[5]))
    else $error("step 6 not chosen");
  a_jog_wins: assert property (
    jog_sel |=> freq_ref_o == $past(preset_mem[8]))
    else $error("jog speed not chosen");
  a_step_one: assert property (
    !jog_ref && step == 3'h0 && freq_src_reg == FS_ANALOG
    |=> freq_ref_o == $past(primary_analog_input_i))
    else $error("step 1 analog not chosen");
  a_step_two: assert property (
    !jog_ref && step == 3'h1 && an2_func_reg == AF_AUX1
    |=> freq_ref_o == $past(second_analog_input_i))
    else $error("step 2 analog not chosen");
  a_step_three: assert property (
    !jog_ref && step == 3'h2 && an3_func_reg == AF_AUX2
    |=> freq_ref_o == $past(third_analog_input_i))
    else $error("step 3 analog not chosen");
  a_func_differ: assert property (
    an2_func_reg != an3_func_reg)
    else $error("analog functions equal");
  a_src_frozen: assert property (
    cmd_o.run |=> $stable(run_src_reg) && run_src_reg <= RS_MAX)
    else $error("run source changed while running");
  a_keypad_stop: assert property (
    run_src_reg == RS_KEYPAD && key_stop_i && !key_jog_i |=> !cmd_o.run)
    else $error("keypad stop ignored");
  a_two_wire: assert property (
    run_src_reg == RS_TERM && !three_wire && forward_run_terminal_i && !stop_term
    |=> cmd_o.run && !cmd_o.rev)
    else $error("two-wire forward not run");
  a_dir_input: assert property (
    tw_act && tw_reg == TW_RUN && stop_term |=> cmd_o.run && cmd_o.rev == $past(dir_in))
    else $error("three-wire direction wrong");
  a_hold_time: assert property (
    tw_reg == TW_RUN && $past(tw_reg) != TW_RUN
    |-> $past(tw_reg) == TW_HOLD && $past(hold_reg) == CW'(RUN_HOLD - 1))
    else $error("run latched early");
  a_stop_opens: assert property (
    tw_act && !stop_term |=> !cmd_o.run)
    else $error("stop contact ignored");

  c_three_wire_run: cover property (tw_act && tw_reg == TW_RUN && !forward_run_terminal_i);
  c_jog_run: cover property (cmd_o.jog);
  c_src_refused: cover property (done && pslverr_reg && idx == IX_RUN_SRC);
endmodule
